// >>> hw/tccg_pkg.sv
// Package for the capture/compare/gated timer: offsets, fields, reset values, modes
package tccg_pkg;

    // ------------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] OFS_COUNT_HI   = 8'h00;
    localparam logic [7:0] OFS_COUNT_LO   = 8'h04;
    localparam logic [7:0] OFS_RELOAD_HI  = 8'h08;
    localparam logic [7:0] OFS_RELOAD_LO  = 8'h0C;
    localparam logic [7:0] OFS_CAPT_HI    = 8'h10;
    localparam logic [7:0] OFS_CAPT_LO    = 8'h14;
    localparam logic [7:0] OFS_CTL0       = 8'h18;
    localparam logic [7:0] OFS_CTL1       = 8'h1C;
    localparam logic [7:0] OFS_STATUS     = 8'h20;

    // ------------------------------------------------------------------
    // Control field positions
    // ------------------------------------------------------------------
    // ctl0: [7] mode_select_msb, [6:5] irq_source_select, [0] capture_cause_flag (RO)
    localparam int CTL0_MODE_MSB = 7;
    localparam int CTL0_IRQ_HI   = 6;
    localparam int CTL0_IRQ_LO   = 5;
    localparam int CTL0_CAUSE    = 0;
    // timer_control_one: [7] enable, [6] polarity, [5:3] prescale, [2:0] mode low
    localparam int CTL1_EN       = 7;
    localparam int CTL1_POL      = 6;
    localparam int CTL1_PRE_HI   = 5;
    localparam int CTL1_PRE_LO   = 3;
    localparam int CTL1_MODE_HI  = 2;
    // status: [0] timer output, [1] interrupt, [2] capture/compare started (first edge seen)
    localparam int ST_OUT        = 0;
    localparam int ST_IRQ        = 1;
    localparam int ST_RUN        = 2;

    // ------------------------------------------------------------------
    // Reset and restart values
    // ------------------------------------------------------------------
    localparam logic [15:0] COUNT_RESET  = 16'h0001;
    localparam logic [15:0] COUNT_RELOAD = 16'h0001;
    localparam logic [15:0] RELOAD_RESET = 16'hFFFF;
    localparam logic [15:0] CAPT_RESET   = 16'h0000;
    localparam logic [7:0]  CTL_RESET    = 8'h00;

    // Four-bit mode codes {mode_select_msb, mode low}
    localparam logic [3:0] MODE_COMPARE   = 4'h5;
    localparam logic [3:0] MODE_GATED     = 4'h6;
    localparam logic [3:0] MODE_CAPCMP    = 4'h7;
    localparam logic [3:0] MODE_CAPRST    = 4'h9;

    // irq_source_select codes
    localparam logic [1:0] IRQ_INPUT_ONLY  = 2'h2;
    localparam logic [1:0] IRQ_RELOAD_ONLY = 2'h3;

    typedef enum logic [3:0] {
        TCCG_COMPARE, TCCG_GATED, TCCG_CAPCMP, TCCG_CAPRST, TCCG_OTHER
    } tccg_mode_t;

    typedef struct packed {
        logic       input_evt;
        logic       reload_evt;
        logic       capture;
        logic       toggle;
    } tccg_evt_t;

endpackage

// >>> hw/tccg_timer.sv
// Capture/compare/gated 16-bit timer with APB register slave
`timescale 1ns/100ps
`default_nettype none
module tccg_timer (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        reset_n,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Timer pins
    input  wire logic        timer_in,
    output logic             timer_out,
    output logic             timer_irq
);

    // ------------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------------
    logic [15:0] count_q, count_d;
    logic [15:0] reload_q, reload_d;
    logic [7:0]  reload_hold_q, reload_hold_d;
    logic [15:0] capt_q, capt_d;
    logic [7:0]  ctl0_q, ctl0_d;
    logic [7:0]  ctl1_q, ctl1_d;
    logic [7:0]  lo_hold_q, lo_hold_d;
    logic        cause_q, cause_d;
    logic        out_q, out_d;
    logic        irq_q, irq_d;
    logic        in_prev_q, in_prev_d;
    logic        started_q, started_d;
    logic [7:0]  pre_cnt_q, pre_cnt_d;
    logic [31:0] prdata_q, prdata_d;

    logic        enable;
    logic        pol;
    logic        tick;
    logic        in_act;
    logic        edge_sel;
    logic        gate_fall;
    logic        wr_en;
    logic        rd_en;
    logic        known;
    tccg_pkg::tccg_mode_t mode;
    tccg_pkg::tccg_evt_t  evt;

    function automatic tccg_pkg::tccg_mode_t decode_mode(input logic [3:0] code);
        unique case (code)
            tccg_pkg::MODE_COMPARE: decode_mode = tccg_pkg::TCCG_COMPARE;
            tccg_pkg::MODE_GATED:   decode_mode = tccg_pkg::TCCG_GATED;
            tccg_pkg::MODE_CAPCMP:  decode_mode = tccg_pkg::TCCG_CAPCMP;
            tccg_pkg::MODE_CAPRST:  decode_mode = tccg_pkg::TCCG_CAPRST;
            default:                decode_mode = tccg_pkg::TCCG_OTHER;
        endcase
    endfunction

    assign enable   = ctl1_q[tccg_pkg::CTL1_EN];
    assign pol      = ctl1_q[tccg_pkg::CTL1_POL];
    assign mode     = decode_mode({ctl0_q[tccg_pkg::CTL0_MODE_MSB],
                                   ctl1_q[tccg_pkg::CTL1_MODE_HI:0]});
    assign in_act   = (timer_in == pol);
    // Edge of selected polarity: rising when pol=1, falling when pol=0
    assign edge_sel = in_act && (in_prev_q != pol) && enable;
    assign gate_fall = !in_act && (in_prev_q == pol) && enable;
    assign wr_en    = psel && penable && pwrite;
    assign rd_en    = psel && penable && !pwrite;
    assign pready   = 1'b1;
    assign known    = (paddr <= tccg_pkg::OFS_STATUS) && (paddr[1:0] == 2'b00);
    assign pslverr  = psel && penable && !known;
    assign prdata   = prdata_q;
    assign timer_out = out_q;
    assign timer_irq = irq_q;

    // ------------------------------------------------------------------
    // Prescaler: divide by 2^prescale, one-cycle tick
    // ------------------------------------------------------------------
    always_comb begin
        logic [7:0] limit;
        limit = 8'(8'h01 << ctl1_q[tccg_pkg::CTL1_PRE_HI:tccg_pkg::CTL1_PRE_LO]);
        tick      = 1'b0;
        pre_cnt_d = pre_cnt_q;
        if (!enable) begin
            pre_cnt_d = 8'h00;
        end else if (pre_cnt_q >= 8'(limit - 8'h01)) begin
            pre_cnt_d = 8'h00;
            tick      = 1'b1;
        end else begin
            pre_cnt_d = 8'(pre_cnt_q + 8'h01);
        end
    end

    // ------------------------------------------------------------------
    // Timer core
    // ------------------------------------------------------------------
    always_comb begin
        logic [1:0] isel;
        logic       irq_ok_in;
        logic       irq_ok_rl;
        isel       = ctl0_q[tccg_pkg::CTL0_IRQ_HI:tccg_pkg::CTL0_IRQ_LO];
        irq_ok_in  = (isel != tccg_pkg::IRQ_RELOAD_ONLY);
        irq_ok_rl  = (isel != tccg_pkg::IRQ_INPUT_ONLY);
        count_d    = count_q;
        capt_d     = capt_q;
        cause_d    = cause_q;
        out_d      = out_q;
        started_d  = enable ? started_q : 1'b0;
        in_prev_d  = timer_in;
        evt        = '0;
        unique case (mode)
            tccg_pkg::TCCG_CAPRST: begin
                if (edge_sel) begin
                    capt_d  = count_q;
                    count_d = tccg_pkg::COUNT_RELOAD;
                    cause_d = 1'b1;
                    evt.input_evt = 1'b1;
                end else if (tick && count_q == reload_q) begin
                    count_d = tccg_pkg::COUNT_RELOAD;
                    cause_d = 1'b0;
                    evt.reload_evt = 1'b1;
                end else if (tick) begin
                    count_d = 16'(count_q + 16'h0001);
                end
            end
            tccg_pkg::TCCG_COMPARE: begin
                if (tick) begin
                    count_d = 16'(count_q + 16'h0001);
                    if (count_q == reload_q) begin
                        evt.reload_evt = 1'b1;
                        out_d = !out_q;
                    end
                end
            end
            tccg_pkg::TCCG_GATED: begin
                if (gate_fall) begin
                    evt.input_evt = 1'b1;
                end
                if (tick && in_act) begin
                    if (count_q == reload_q) begin
                        count_d = tccg_pkg::COUNT_RELOAD;
                        evt.reload_evt = 1'b1;
                        out_d = !out_q;
                    end else begin
                        count_d = 16'(count_q + 16'h0001);
                    end
                end
            end
            tccg_pkg::TCCG_CAPCMP: begin
                if (edge_sel && !started_q) begin
                    started_d = 1'b1;
                end else if (edge_sel) begin
                    capt_d  = count_q;
                    count_d = tccg_pkg::COUNT_RELOAD;
                    cause_d = 1'b1;
                    evt.input_evt = 1'b1;
                end else if (started_q && tick && count_q == reload_q) begin
                    count_d = tccg_pkg::COUNT_RELOAD;
                    cause_d = 1'b0;
                    evt.reload_evt = 1'b1;
                end else if (started_q && tick) begin
                    count_d = 16'(count_q + 16'h0001);
                end
            end
            default: begin
                if (tick) begin
                    count_d = 16'(count_q + 16'h0001);
                end
            end
        endcase
        // One-cycle interrupt pulse, filtered by source selection
        irq_d = (evt.input_evt && irq_ok_in) || (evt.reload_evt && irq_ok_rl);
        // Software writes override the counter only while it is written
        if (wr_en && paddr == tccg_pkg::OFS_COUNT_HI) begin
            count_d = {pwdata[7:0], count_d[7:0]};
        end
        if (wr_en && paddr == tccg_pkg::OFS_COUNT_LO) begin
            count_d = {count_d[15:8], pwdata[7:0]};
        end
        if (wr_en && paddr == tccg_pkg::OFS_CAPT_HI) begin
            capt_d = {pwdata[7:0], capt_d[7:0]};
        end
        if (wr_en && paddr == tccg_pkg::OFS_CAPT_LO) begin
            capt_d = {capt_d[15:8], pwdata[7:0]};
        end
    end

    // ------------------------------------------------------------------
    // Register writes and reads
    // ------------------------------------------------------------------
    always_comb begin
        reload_d      = reload_q;
        reload_hold_d = reload_hold_q;
        ctl0_d        = ctl0_q;
        ctl1_d        = ctl1_q;
        lo_hold_d     = lo_hold_q;
        prdata_d      = prdata_q;
        if (wr_en) begin
            unique case (paddr)
                // High byte waits so the 16-bit reload updates at once
                tccg_pkg::OFS_RELOAD_HI: reload_hold_d = pwdata[7:0];
                tccg_pkg::OFS_RELOAD_LO: reload_d = {reload_hold_q, pwdata[7:0]};
                tccg_pkg::OFS_CTL0:      ctl0_d = {pwdata[7:5], 5'h00};
                tccg_pkg::OFS_CTL1:      ctl1_d = pwdata[7:0];
                default:                 ;
            endcase
        end
        if (rd_en) begin
            unique case (paddr)
                tccg_pkg::OFS_COUNT_HI: begin
                    prdata_d = {24'h000000, count_q[15:8]};
                    if (enable) begin
                        lo_hold_d = count_q[7:0];
                    end
                end
                tccg_pkg::OFS_COUNT_LO:
                    prdata_d = {24'h000000, enable ? lo_hold_q : count_q[7:0]};
                tccg_pkg::OFS_RELOAD_HI: prdata_d = {24'h000000, reload_q[15:8]};
                tccg_pkg::OFS_RELOAD_LO: prdata_d = {24'h000000, reload_q[7:0]};
                tccg_pkg::OFS_CAPT_HI:   prdata_d = {24'h000000, capt_q[15:8]};
                tccg_pkg::OFS_CAPT_LO:   prdata_d = {24'h000000, capt_q[7:0]};
                tccg_pkg::OFS_CTL0:
                    prdata_d = {24'h000000, ctl0_q[7:1], cause_q};
                tccg_pkg::OFS_CTL1:      prdata_d = {24'h000000, ctl1_q};
                tccg_pkg::OFS_STATUS:
                    prdata_d = {29'h00000000, started_q, irq_q, out_q};
                default:                 prdata_d = 32'h00000000;
            endcase
        end
    end

    // Reads only touch prdata and the low-byte holder, never the counter
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            count_q       <= tccg_pkg::COUNT_RESET;
            reload_q      <= tccg_pkg::RELOAD_RESET;
            reload_hold_q <= tccg_pkg::RELOAD_RESET[15:8];
            capt_q        <= tccg_pkg::CAPT_RESET;
            ctl0_q        <= tccg_pkg::CTL_RESET;
            ctl1_q        <= tccg_pkg::CTL_RESET;
            lo_hold_q     <= 8'h00;
            cause_q       <= 1'b0;
            out_q         <= 1'b0;
            irq_q         <= 1'b0;
            in_prev_q     <= 1'b0;
            started_q     <= 1'b0;
            pre_cnt_q     <= 8'h00;
            prdata_q      <= 32'h00000000;
        end else begin
            count_q       <= count_d;
            reload_q      <= reload_d;
            reload_hold_q <= reload_hold_d;
            capt_q        <= capt_d;
            ctl0_q        <= ctl0_d;
            ctl1_q        <= ctl1_d;
            lo_hold_q     <= lo_hold_d;
            cause_q       <= cause_d;
            out_q         <= out_d;
            irq_q         <= irq_d;
            in_prev_q     <= in_prev_d;
            started_q     <= started_d;
            pre_cnt_q     <= pre_cnt_d;
            prdata_q      <= prdata_d;
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    caprst_restart_a: assert property (@(posedge clk) disable iff (!reset_n)
        (mode == tccg_pkg::TCCG_CAPRST && edge_sel && !wr_en)
        |=> (count_q == 16'h0001 && cause_q && capt_q == $past(count_q)))
        else $error("capture restart failed");
    caprst_reload_a: assert property (@(posedge clk) disable iff (!reset_n)
        (mode == tccg_pkg::TCCG_CAPRST && !edge_sel && tick && count_q == reload_q && !wr_en)
        |=> (count_q == 16'h0001 && !cause_q))
        else $error("capture restart reload failed");
    compare_toggle_a: assert property (@(posedge clk) disable iff (!reset_n)
        (mode == tccg_pkg::TCCG_COMPARE && tick && count_q == reload_q && !wr_en)
        |=> (out_q != $past(out_q) && count_q == 16'($past(count_q) + 16'h0001)))
        else $error("compare match failed");
    gated_hold_a: assert property (@(posedge clk) disable iff (!reset_n)
        (mode == tccg_pkg::TCCG_GATED && !in_act && !wr_en) |=> $stable(count_q))
        else $error("gated counted while inactive");
    gated_fall_a: assert property (@(posedge clk) disable iff (!reset_n)
        (mode == tccg_pkg::TCCG_GATED && gate_fall
         && ctl0_q[tccg_pkg::CTL0_IRQ_HI:tccg_pkg::CTL0_IRQ_LO] != tccg_pkg::IRQ_RELOAD_ONLY)
        |=> timer_irq)
        else $error("gate deassert irq missing");
    capcmp_first_a: assert property (@(posedge clk) disable iff (!reset_n)
        (mode == tccg_pkg::TCCG_CAPCMP && edge_sel && !started_q) |=> !timer_irq)
        else $error("first edge raised irq");
    irq_filter_a: assert property (@(posedge clk) disable iff (!reset_n)
        (ctl0_q[tccg_pkg::CTL0_IRQ_HI:tccg_pkg::CTL0_IRQ_LO] == tccg_pkg::IRQ_INPUT_ONLY
         && !evt.input_evt) |=> !timer_irq)
        else $error("filtered irq raised");
    // APB needs a setup cycle, so the low read completes three edges after the high read
    low_hold_a: assert property (@(posedge clk) disable iff (!reset_n)
        (rd_en && paddr == tccg_pkg::OFS_COUNT_HI && enable) ##1
        (!rd_en && enable) [*2] ##1
        (rd_en && paddr == tccg_pkg::OFS_COUNT_LO && enable)
        |=> prdata_q[7:0] == $past(count_q[7:0], 4))
        else $error("held low byte wrong");

endmodule
`default_nettype wire

// >>> sim/tccg_pin_model.sv
// Timer input pin model driven from a bench-side gate request
`timescale 1ns/100ps
`default_nettype none
module tccg_pin_model (
    // Clock and reset
    input  wire logic clk,
    input  wire logic reset_n,
    // Request and pin
    input  wire logic gate_req,
    output logic      timer_in
);
    logic pin_q;
    logic pin_d;

    // Pin only moves after a clock edge, never in the sampling instant
    always_comb pin_d = gate_req;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n)
            pin_q <= 1'b0;
        else
            pin_q <= pin_d;
    end
    assign timer_in = pin_q;
endmodule
`default_nettype wire

// >>> sim/test_timer_capture_compare_gated_modes.sv
// Self-checking bench for the capture/compare/gated timer
`timescale 1ns/100ps
`default_nettype none
module test_timer_capture_compare_gated_modes;
    typedef struct packed {
        logic [31:0] d;
        logic        on;
    } tccg_exp_t;

    logic        clk, reset_n, psel, penable, pwrite, pready, pslverr;
    logic        timer_in, timer_out, timer_irq, gate_req, rd_d, out_q;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, v, w;
    tccg_exp_t   exp_q[$];
    tccg_exp_t   ent;
    int          n_fail, cmp_count, irq_n, tog_n, seed, base, tog0;
    logic [1:0]  codes[3] = '{2'h0, tccg_pkg::IRQ_INPUT_ONLY, tccg_pkg::IRQ_RELOAD_ONLY};
    int          nirq[3]  = '{2, 1, 1};

    tccg_timer dut (.clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .timer_in(timer_in), .timer_out(timer_out), .timer_irq(timer_irq));
    tccg_pin_model u_pin (.clk(clk), .reset_n(reset_n), .gate_req(gate_req),
        .timer_in(timer_in));

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // ------------------------------------------------------------
    // Checking and bus tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Read data lands one cycle after the access edge
    always @(posedge clk) begin
        if (rd_d && exp_q.size() > 0) begin
            ent = exp_q.pop_front();
            if (ent.on)
                chk(prdata, ent.d);
        end
        rd_d <= psel && penable && !pwrite && pready;
        if (timer_irq === 1'b1)
            irq_n++;
        if (timer_out !== out_q)
            tog_n++;
        out_q <= timer_out;
    end

    task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d,
                       input logic [7:0] e, input logic on);
        int n;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= (32'($random(seed)) & 32'hFFFFFF00) | {24'h0, d};
        if (!wr)
            exp_q.push_back('{{24'h0, e}, on});
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        chk({31'h0, pslverr}, {31'h0, a > 8'h20});
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
        v = prdata;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        apb(1'b1, a, d, 8'h00, 1'b0);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        apb(1'b0, a, 8'h00, e, 1'b1);
    endtask
    task automatic rdv(input logic [7:0] a);
        apb(1'b0, a, 8'h00, 8'h00, 1'b0);
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic cfg(input logic [7:0] c0, c1, input logic [15:0] st, rl);
        wr(tccg_pkg::OFS_CTL1, c1 & 8'h7F);
        wr(tccg_pkg::OFS_CTL0, c0);
        wr(tccg_pkg::OFS_COUNT_HI, st[15:8]);
        wr(tccg_pkg::OFS_COUNT_LO, st[7:0]);
        wr(tccg_pkg::OFS_RELOAD_HI, rl[15:8]);
        wr(tccg_pkg::OFS_RELOAD_LO, rl[7:0]);
        wr(tccg_pkg::OFS_CTL1, c1);
        base = irq_n;
        tog0 = tog_n;
    endtask

    task automatic conclude;
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    initial begin
        seed = 32'h3603b3fd;
        {psel, penable, pwrite, gate_req, reset_n, out_q, rd_d} = '0;
        paddr = 8'h00;
        pwdata = 32'h0;
        {n_fail, cmp_count, irq_n, tog_n} = '0;
        repeat (8) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        rd(tccg_pkg::OFS_COUNT_HI, 8'h00);
        rd(tccg_pkg::OFS_COUNT_LO, 8'h01);
        rd(tccg_pkg::OFS_RELOAD_HI, 8'hFF);
        rd(tccg_pkg::OFS_RELOAD_LO, 8'hFF);
        rd(tccg_pkg::OFS_CAPT_LO, 8'h00);
        rd(tccg_pkg::OFS_CTL0, 8'h00);
        rd(8'h24, 8'h00);
        $display("test reset done");
        cfg(8'h00, 8'h85, 16'hFFF0, 16'h0005);
        cyc(40);
        chk(irq_n - base, 1);
        chk(tog_n - tog0, 1);
        wr(tccg_pkg::OFS_CTL1, 8'h05);
        rd(tccg_pkg::OFS_STATUS, 8'h01);
        rd(tccg_pkg::OFS_COUNT_HI, 8'h00);
        rdv(tccg_pkg::OFS_COUNT_LO);
        chk(v[7:0] > 8'h05, 1);
        $display("test compare done");
        foreach (codes[i]) begin
            cfg({1'b1, codes[i], 5'h0}, 8'hC1, 16'h0001, 16'h0040);
            cyc(10 + ($random(seed) & 7));
            gate_req <= 1'b1;
            cyc(4);
            rd(tccg_pkg::OFS_COUNT_HI, 8'h00);
            rdv(tccg_pkg::OFS_COUNT_LO);
            chk(v[7:0] < 8'h10, 1);
            rdv(tccg_pkg::OFS_CAPT_LO);
            chk(v[7:0] > 8'h08, 1);
            if (codes[i] == 2'h0)
                rd(tccg_pkg::OFS_CTL0, 8'h81);
            gate_req <= 1'b0;
            cyc(80);
            if (codes[i] == 2'h0)
                rd(tccg_pkg::OFS_CTL0, 8'h80);
            chk(irq_n - base, nirq[i]);
            wr(tccg_pkg::OFS_CTL1, 8'h41);
        end
        $display("test capture restart done");
        cfg(8'h00, 8'hC6, 16'h0030, 16'h0040);
        cyc(10);
        rd(tccg_pkg::OFS_COUNT_HI, 8'h00);
        rd(tccg_pkg::OFS_COUNT_LO, 8'h30);
        gate_req <= 1'b1;
        cyc(30);
        gate_req <= 1'b0;
        cyc(6);
        chk(irq_n - base, 2);
        chk(tog_n - tog0, 1);
        rd(tccg_pkg::OFS_COUNT_HI, 8'h00);
        rdv(tccg_pkg::OFS_COUNT_LO);
        w = v;
        chk(v[7:0] < 8'h30, 1);
        rd(tccg_pkg::OFS_COUNT_HI, 8'h00);
        rdv(tccg_pkg::OFS_COUNT_LO);
        chk(v, w);
        wr(tccg_pkg::OFS_CTL1, 8'h46);
        $display("test gated done");
        cfg(8'h00, 8'hC7, 16'h0001, 16'h0100);
        cyc(20);
        rd(tccg_pkg::OFS_COUNT_HI, 8'h00);
        rd(tccg_pkg::OFS_COUNT_LO, 8'h01);
        gate_req <= 1'b1;
        cyc(6);
        chk(irq_n - base, 0);
        gate_req <= 1'b0;
        cyc(30 + ($random(seed) & 7));
        gate_req <= 1'b1;
        cyc(6);
        chk(irq_n - base, 1);
        rd(tccg_pkg::OFS_CTL0, 8'h01);
        rdv(tccg_pkg::OFS_CAPT_LO);
        chk(v[7:0] > 8'h20, 1);
        gate_req <= 1'b0;
        cyc(280);
        chk(irq_n - base, 2);
        rd(tccg_pkg::OFS_CTL0, 8'h00);
        $display("test capture compare done");
        conclude();
    end

    // Whole run is near 950 cycles; this bound leaves wide margin
    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        conclude();
    end
endmodule
`default_nettype wire
